// >>> core/ipc_map.svh
`ifndef IPC_MAP_SVH
`define IPC_MAP_SVH

// register byte addresses
`define IPC_POWER_CONTROL_ADDR   8'h87
`define IPC_WAKE_ENABLE_ADDR     8'h88
`define IPC_STATUS_ADDR          8'h8C

// power_control fields
`define IPC_IDLE_BIT             0
`define IPC_PD_BIT               1
`define IPC_GF0_BIT              2
`define IPC_GF1_BIT              3
`define IPC_POF_BIT              4
`define IPC_RSVD_BIT             5
`define IPC_SERIAL_FRAMING_SELECT_BIT            6
`define IPC_SERIAL_BAUD_DOUBLER_BIT             7
`define IPC_POWER_CONTROL_WMASK           8'hDF

// wake_enable fields
`define IPC_WE_EXT0_BIT          0
`define IPC_WE_EXT1_BIT          1
`define IPC_WE_KEYPAD_BIT        2
`define IPC_WE_BOD_BIT           3
`define IPC_WE_WDT_BIT           4
`define IPC_WE_GLOBAL_BIT        7

// clock settle time after wake
`define IPC_SETTLE_NS            1000
`define IPC_CLK_PERIOD_NS        50
`define IPC_SETTLE_CYC           ((`IPC_SETTLE_NS + `IPC_CLK_PERIOD_NS - 1) / `IPC_CLK_PERIOD_NS)

// axi responses
`define IPC_RESP_OKAY            2'h0
`define IPC_RESP_SLVERR          2'h2

`endif

// >>> core/ipc_pkg.sv
package ipc_pkg;
   typedef enum logic [1:0] {
      IPC_RUN    = 2'h0,
      IPC_IDLE   = 2'h1,
      IPC_PDOWN  = 2'h3,
      IPC_SETTLE = 2'h2
   } ipc_mode_e;
   typedef logic [7:0] ipc_byte_t;
endpackage : ipc_pkg

// >>> core/ipc_keypad_wake.sv
`timescale 1ns/1ps
// keypad edge detector: direction armed from level at power-down entry
module ipc_keypad_wake #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   // control
   input  wire logic             arm_in,
   // pins, already synchronised
   input  wire logic [WIDTH-1:0] pins_in,
   // result
   output logic                  wake_out
);
   logic [WIDTH-1:0] armed_level_r;
   logic [WIDTH-1:0] prev_r;
   logic [WIDTH-1:0] hit;

   initial begin
      if (WIDTH < 1 || WIDTH > 8) $error("ipc_keypad_wake: WIDTH must be 1..8");
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         armed_level_r <= '0;
         prev_r        <= '0;
      end else begin
         prev_r <= pins_in;
         if (arm_in) begin
            armed_level_r <= pins_in;
         end
      end
   end

   // low at entry wakes on rise only, high at entry on fall only
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_pin
         assign hit[g] = armed_level_r[g] ? (prev_r[g] & ~pins_in[g])
                                          : (~prev_r[g] & pins_in[g]);
      end
   endgenerate

   assign wake_out = |hit;
endmodule : ipc_keypad_wake

// >>> core/ipc_idle_powerdown_controller.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ipc_map.svh"
//
// Overview of operation
// - watchdog counter cleared on entering and on waking from idle or power-down
// - power_control at 87H: bit1 power-down, bit0 idle, bit4 power-on, bits 3,2 flags
// - power-down request stops CPU and peripheral clocks and freezes program counter
// - power-down wake clears request bit and vectors to waking interrupt
// - both request bits set enters power-down only, never idle afterwards
// - idle stops CPU clock, holds program counter, keeps registers and pins
// - idle keeps peripheral clocks; enabled interrupt ends idle, clears idle bit
// - after idle service routine, execution resumes after the entering instruction
// - idle-entering write is the last instruction before CPU halts
// - any reset except software reset ends idle
// - power-down halts whole clock system and flash, keeps RAM and port latches
// - power-down-entering write is the last instruction executed
// - every reset except software reset releases power-down, brown-out included
// - pin or power-on reset leaving power-down restarts CPU at reset address
// - external pin wakes power-down only with its enable and global enable
// - brown-out, watchdog and keypad interrupts also wake power-down
// - keypad pin wakes on edge opposite to its level at power-down entry
// - power-on flag set when power-on reset completes; software may clear
//
module ipc_idle_powerdown_controller #(
   parameter int KEYPAD_WIDTH = 8,
   parameter int SETTLE_CYC   = `IPC_SETTLE_CYC
) (
   // clock and reset
   input  wire logic                    SYS_CLK_IN,
   input  wire logic                    RST_N_IN,
   // axi4-lite write
   input  wire logic [7:0]              S_AXI_AWADDR_IN,
   input  wire logic                    S_AXI_AWVALID_IN,
   output logic                         S_AXI_AWREADY_OUT,
   input  wire logic [31:0]             S_AXI_WDATA_IN,
   input  wire logic [3:0]              S_AXI_WSTRB_IN,
   input  wire logic                    S_AXI_WVALID_IN,
   output logic                         S_AXI_WREADY_OUT,
   output logic [1:0]                   S_AXI_BRESP_OUT,
   output logic                         S_AXI_BVALID_OUT,
   input  wire logic                    S_AXI_BREADY_IN,
   // axi4-lite read
   input  wire logic [7:0]              S_AXI_ARADDR_IN,
   input  wire logic                    S_AXI_ARVALID_IN,
   output logic                         S_AXI_ARREADY_OUT,
   output logic [31:0]                  S_AXI_RDATA_OUT,
   output logic [1:0]                   S_AXI_RRESP_OUT,
   output logic                         S_AXI_RVALID_OUT,
   input  wire logic                    S_AXI_RREADY_IN,
   // reset sources (software reset is not an input: it never wakes)
   input  wire logic                    POR_DONE_IN,
   input  wire logic                    PIN_RESET_IN,
   input  wire logic                    WDT_RESET_IN,
   input  wire logic                    BOD_RESET_IN,
   // wake sources
   input  wire logic                    IRQ_PENDING_IN,
   input  wire logic [1:0]              EXT_IRQ_PINS_IN,
   input  wire logic [KEYPAD_WIDTH-1:0] KEYPAD_PINS_IN,
   input  wire logic                    BOD_IRQ_IN,
   input  wire logic                    WDT_IRQ_IN,
   // cpu side
   output logic                         CPU_CLK_EN_OUT,
   output logic                         PERIPH_CLK_EN_OUT,
   output logic                         OSC_EN_OUT,
   output logic                         FLASH_EN_OUT,
   output logic                         CPU_RESTART_OUT,
   output logic                         VECTOR_GO_OUT,
   output logic                         WDT_CLEAR_OUT,
   output logic                         SERIAL_BAUD_DOUBLER_OUT,
   output logic                         SERIAL_FRAMING_SELECT_OUT
);

   ////////////////////////////////////////////////////////////////////////////
   ipc_pkg::ipc_mode_e              mode_r;
   ipc_pkg::ipc_byte_t              power_control_r;
   ipc_pkg::ipc_byte_t              wake_en_r;
   logic [1:0]                      ext_s1_r, ext_s2_r;
   logic [KEYPAD_WIDTH-1:0]         kp_s1_r, kp_s2_r;
   logic [$clog2(SETTLE_CYC+1)-1:0] settle_r;
   logic                            aw_hold_r, w_hold_r;
   logic [7:0]                      aw_addr_r;
   logic [31:0]                     w_data_r;
   logic [3:0]                      w_strb_r;
   logic                            kp_wake;
   logic                            hw_reset;
   logic                            wr_fire;
   logic                            power_control_wr;
   logic                            pd_wake;
   logic                            idle_wake;
   ipc_pkg::ipc_mode_e              prev_mode_r;
   ipc_pkg::ipc_byte_t              rd_byte;

   default clocking ast_cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   initial begin
      if (SETTLE_CYC < 1) $error("SETTLE_CYC must be at least 1");
   end

   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a == `IPC_POWER_CONTROL_ADDR) || (a == `IPC_WAKE_ENABLE_ADDR)
                 || (a == `IPC_STATUS_ADDR);
   endfunction : addr_hit

   // software reset deliberately absent
   assign hw_reset = POR_DONE_IN | PIN_RESET_IN | WDT_RESET_IN | BOD_RESET_IN;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ext_s1_r <= '0;
         ext_s2_r <= '0;
         kp_s1_r  <= '0;
         kp_s2_r  <= '0;
      end else begin
         ext_s1_r <= EXT_IRQ_PINS_IN;
         ext_s2_r <= ext_s1_r;
         kp_s1_r  <= KEYPAD_PINS_IN;
         kp_s2_r  <= kp_s1_r;
      end
   end

   ipc_keypad_wake #(
      .WIDTH (KEYPAD_WIDTH)
   ) u_keypad (
      .clk_in   (SYS_CLK_IN),
      .rst_n_in (RST_N_IN),
      .arm_in   (mode_r != ipc_pkg::IPC_PDOWN),
      .pins_in  (kp_s2_r),
      .wake_out (kp_wake)
   );

   // external pins active low; need own enable and global enable
   assign pd_wake = (wake_en_r[`IPC_WE_GLOBAL_BIT] &
                     ((~ext_s2_r[0] & wake_en_r[`IPC_WE_EXT0_BIT]) |
                      (~ext_s2_r[1] & wake_en_r[`IPC_WE_EXT1_BIT]) |
                      (kp_wake & wake_en_r[`IPC_WE_KEYPAD_BIT]) |
                      (BOD_IRQ_IN & wake_en_r[`IPC_WE_BOD_BIT]) |
                      (WDT_IRQ_IN & wake_en_r[`IPC_WE_WDT_BIT])));
   assign idle_wake = IRQ_PENDING_IN;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write: address and data captured in either order
   assign wr_fire = aw_hold_r && w_hold_r && !S_AXI_BVALID_OUT;
   assign power_control_wr = wr_fire && aw_addr_r == `IPC_POWER_CONTROL_ADDR && w_strb_r[0];

   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         aw_hold_r         <= 1'b0;
         w_hold_r          <= 1'b0;
         aw_addr_r         <= 8'h00;
         w_data_r          <= 32'h00000000;
         w_strb_r          <= 4'h0;
         S_AXI_AWREADY_OUT <= 1'b0;
         S_AXI_WREADY_OUT  <= 1'b0;
         S_AXI_BVALID_OUT  <= 1'b0;
         S_AXI_BRESP_OUT   <= `IPC_RESP_OKAY;
      end else begin
         S_AXI_AWREADY_OUT <= !aw_hold_r && !S_AXI_AWREADY_OUT;
         S_AXI_WREADY_OUT  <= !w_hold_r && !S_AXI_WREADY_OUT;
         if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            aw_hold_r         <= 1'b1;
            aw_addr_r         <= S_AXI_AWADDR_IN;
            S_AXI_AWREADY_OUT <= 1'b0;
         end
         if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            w_hold_r         <= 1'b1;
            w_data_r         <= S_AXI_WDATA_IN;
            w_strb_r         <= S_AXI_WSTRB_IN;
            S_AXI_WREADY_OUT <= 1'b0;
         end
         if (wr_fire) begin
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT  <= addr_hit(aw_addr_r) ? `IPC_RESP_OKAY : `IPC_RESP_SLVERR;
         end
         if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
            aw_hold_r        <= 1'b0;
            w_hold_r         <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read: one read in flight, word captured with the address
   always_comb begin
      case (S_AXI_ARADDR_IN)
         `IPC_POWER_CONTROL_ADDR: rd_byte = power_control_r;
         `IPC_WAKE_ENABLE_ADDR:   rd_byte = wake_en_r;
         `IPC_STATUS_ADDR:        rd_byte = {6'h00, mode_r};
         default:                 rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         S_AXI_ARREADY_OUT <= 1'b0;
         S_AXI_RVALID_OUT  <= 1'b0;
         S_AXI_RDATA_OUT   <= 32'h00000000;
         S_AXI_RRESP_OUT   <= `IPC_RESP_OKAY;
      end else begin
         S_AXI_ARREADY_OUT <= !S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT;
         if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            S_AXI_ARREADY_OUT <= 1'b0;
            S_AXI_RVALID_OUT  <= 1'b1;
            S_AXI_RDATA_OUT   <= {24'h000000, rd_byte};
            S_AXI_RRESP_OUT   <= addr_hit(S_AXI_ARADDR_IN) ? `IPC_RESP_OKAY : `IPC_RESP_SLVERR;
         end
         if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power_control and wake enable; hardware clear wins over a same-cycle write
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         power_control_r    <= 8'h00;
         wake_en_r <= 8'h00;
      end else begin
         if (power_control_wr) begin
            power_control_r <= (w_data_r[7:0] & `IPC_POWER_CONTROL_WMASK) | (power_control_r & ~`IPC_POWER_CONTROL_WMASK);
         end
         if (wr_fire && aw_addr_r == `IPC_WAKE_ENABLE_ADDR && w_strb_r[0]) begin
            wake_en_r <= w_data_r[7:0];
         end
         if (POR_DONE_IN) begin
            power_control_r[`IPC_POF_BIT] <= 1'b1;
         end
         if (mode_r == ipc_pkg::IPC_PDOWN && (pd_wake || hw_reset)) begin
            power_control_r[`IPC_PD_BIT]   <= 1'b0;
            power_control_r[`IPC_IDLE_BIT] <= 1'b0;
         end
         if (mode_r == ipc_pkg::IPC_IDLE && (idle_wake || hw_reset)) begin
            power_control_r[`IPC_IDLE_BIT] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode machine; the write is the last instruction since the clock enable drops two edges after it
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         mode_r          <= ipc_pkg::IPC_RUN;
         settle_r        <= '0;
         CPU_RESTART_OUT <= 1'b0;
         VECTOR_GO_OUT   <= 1'b0;
      end else begin
         CPU_RESTART_OUT <= 1'b0;
         VECTOR_GO_OUT   <= 1'b0;
         case (mode_r)
            ipc_pkg::IPC_RUN: begin
               if (power_control_wr && w_data_r[`IPC_PD_BIT]) begin
                  mode_r <= ipc_pkg::IPC_PDOWN;
               end else if (power_control_wr && w_data_r[`IPC_IDLE_BIT]) begin
                  mode_r <= ipc_pkg::IPC_IDLE;
               end
            end
            ipc_pkg::IPC_IDLE: begin
               if (hw_reset) begin
                  mode_r          <= ipc_pkg::IPC_RUN;
                  CPU_RESTART_OUT <= 1'b1;
               end else if (idle_wake) begin
                  mode_r        <= ipc_pkg::IPC_RUN;
                  VECTOR_GO_OUT <= 1'b1;
               end
            end
            ipc_pkg::IPC_PDOWN: begin
               if (hw_reset) begin
                  mode_r          <= ipc_pkg::IPC_RUN;
                  CPU_RESTART_OUT <= 1'b1;
               end else if (pd_wake) begin
                  mode_r   <= ipc_pkg::IPC_SETTLE;
                  settle_r <= $bits(settle_r)'(SETTLE_CYC);
               end
            end
            ipc_pkg::IPC_SETTLE: begin
               if (settle_r > 1) begin
                  settle_r <= settle_r - 1'b1;
               end else begin
                  mode_r        <= ipc_pkg::IPC_RUN;
                  VECTOR_GO_OUT <= 1'b1;
               end
            end
            default: mode_r <= ipc_pkg::IPC_RUN;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock gates and watchdog clear pulse on every transition
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         CPU_CLK_EN_OUT    <= 1'b1;
         PERIPH_CLK_EN_OUT <= 1'b1;
         OSC_EN_OUT        <= 1'b1;
         FLASH_EN_OUT      <= 1'b1;
         WDT_CLEAR_OUT     <= 1'b0;
      end else begin
         CPU_CLK_EN_OUT    <= (mode_r == ipc_pkg::IPC_RUN);
         PERIPH_CLK_EN_OUT <= (mode_r == ipc_pkg::IPC_RUN) ||
                              (mode_r == ipc_pkg::IPC_IDLE);
         OSC_EN_OUT        <= (mode_r != ipc_pkg::IPC_PDOWN);
         FLASH_EN_OUT      <= (mode_r != ipc_pkg::IPC_PDOWN);
         WDT_CLEAR_OUT     <= (mode_r != prev_mode_r);
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         prev_mode_r <= ipc_pkg::IPC_RUN;
      end else begin
         prev_mode_r <= mode_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   AST_PD_CLOCKS_STOP: assert property (mode_r == ipc_pkg::IPC_PDOWN |=>
      {CPU_CLK_EN_OUT, PERIPH_CLK_EN_OUT, OSC_EN_OUT} == 3'h0) else $error("clock left on");
   AST_IDLE_CLOCKS: assert property (mode_r == ipc_pkg::IPC_IDLE |=>
      !CPU_CLK_EN_OUT && PERIPH_CLK_EN_OUT) else $error("idle gating wrong");
   AST_WDT_CLEAR: assert property (mode_r != $past(mode_r) |=> WDT_CLEAR_OUT)
      else $error("watchdog not cleared on mode change");
   AST_SETTLE_HOLD: assert property (mode_r == ipc_pkg::IPC_SETTLE |->
      !CPU_CLK_EN_OUT && !VECTOR_GO_OUT) else $error("cpu released before settle");
   AST_PD_WAKE: assert property (mode_r == ipc_pkg::IPC_PDOWN && (pd_wake || hw_reset) |=>
      power_control_r[`IPC_PD_BIT:`IPC_IDLE_BIT] == 2'h0) else $error("request bits left set");
   AST_IDLE_WAKE: assert property (mode_r == ipc_pkg::IPC_IDLE && idle_wake |=>
      mode_r == ipc_pkg::IPC_RUN && !power_control_r[`IPC_IDLE_BIT]) else $error("idle not ended");

   assign SERIAL_BAUD_DOUBLER_OUT   = power_control_r[`IPC_SERIAL_BAUD_DOUBLER_BIT];
   assign SERIAL_FRAMING_SELECT_OUT = power_control_r[`IPC_SERIAL_FRAMING_SELECT_BIT];
endmodule : ipc_idle_powerdown_controller

// >>> testbench/ipc_cpu_model.sv
`timescale 1ns/1ps
// stands in for cpu core, interrupt logic and reset sources
module ipc_cpu_model (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // controller side
   input  wire logic        cpu_clk_en_in,
   output logic [9:0]       src_out,
   output logic [1:0]       ext_n_out,
   output logic [7:0]       keypad_out,
   output logic [15:0]      pc_out
);
   initial begin
      src_out    = '0;
      ext_n_out  = 2'h3;
      keypad_out = 8'h00;
   end

   // instruction counter moves only while the cpu clock runs
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) pc_out <= 16'h0000;
      else if (cpu_clk_en_in) pc_out <= pc_out + 16'h0001;
   end

   // 0,1 external pins (low active), 2 keypad, 3.. single-bit sources
   task automatic fire(input int k);
      if (k < 2) ext_n_out[k] <= 1'b0;
      else if (k == 2) keypad_out <= 8'h01;
      else src_out[k] <= 1'b1;
      repeat (3) @(posedge clk_in);
      ext_n_out  <= 2'h3;
      src_out    <= '0;
      keypad_out <= 8'h00;
   endtask : fire
endmodule : ipc_cpu_model

// >>> testbench/tb.sv
`timescale 1ns/1ps
`include "ipc_map.svh"
module tb;
   localparam int SETTLE = 20;
   logic              clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]        awaddr, araddr, b;
   logic [31:0]       wdata, d;
   logic [3:0]        wstrb;
   logic [1:0]        r;
   wire logic         awready, wready, bvalid, arready, rvalid;
   wire logic [1:0]   bresp, rresp, ext_n;
   wire logic [31:0]  rdata;
   wire logic         cpu_en, per_en, osc_en, fl_en, restart, vec, wclr, baud, frm;
   wire logic [9:0]   src;
   wire logic [7:0]   kp;
   wire logic [15:0]  pc;
   int                fail_count, n_compared, wdt_n, rst_cnt, vec_n, i, n, w0, r0, v0;
   integer            seed;

   ipc_idle_powerdown_controller #(.KEYPAD_WIDTH(8), .SETTLE_CYC(SETTLE))
   ipc_idle_powerdown_controller_i (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
      .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
      .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
      .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
      .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
      .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
      .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .POR_DONE_IN(src[8]),
      .PIN_RESET_IN(src[5]), .WDT_RESET_IN(src[6]), .BOD_RESET_IN(src[7]),
      .IRQ_PENDING_IN(src[9]), .EXT_IRQ_PINS_IN(ext_n), .KEYPAD_PINS_IN(kp),
      .BOD_IRQ_IN(src[3]), .WDT_IRQ_IN(src[4]), .CPU_CLK_EN_OUT(cpu_en),
      .PERIPH_CLK_EN_OUT(per_en), .OSC_EN_OUT(osc_en), .FLASH_EN_OUT(fl_en),
      .CPU_RESTART_OUT(restart), .VECTOR_GO_OUT(vec), .WDT_CLEAR_OUT(wclr),
      .SERIAL_BAUD_DOUBLER_OUT(baud), .SERIAL_FRAMING_SELECT_OUT(frm));

   ipc_cpu_model ipc_cpu_model_i (.clk_in(clk), .rst_n_in(rst_n), .cpu_clk_en_in(cpu_en),
      .src_out(src), .ext_n_out(ext_n), .keypad_out(kp), .pc_out(pc));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // pulse counters, read a couple of edges after the event
   always @(posedge clk) begin
      wdt_n   <= wdt_n + (wclr === 1'b1);
      rst_cnt <= rst_cnt + (restart === 1'b1);
      vec_n   <= vec_n + (vec === 1'b1);
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic results();
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results

   task automatic timeout();
      check(32'h0, 32'h1);
      results();
   endtask : timeout

   task automatic axw(input logic [7:0] a, input logic [7:0] v);
      // an edge passes so a response ready just dropped is not raised in the same step
      @(posedge clk);
      awaddr  <= a;
      wdata   <= {24'h000000, v};
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int k = 0; k < 100; k++) begin
         @(posedge clk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            bready <= 1'b0;
            r = bresp;
            return;
         end
      end
      timeout();
   endtask : axw

   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int k = 0; k < 100; k++) begin
         @(posedge clk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            rready <= 1'b0;
            d = rdata;
            r = rresp;
            return;
         end
      end
      timeout();
   endtask : axr

   task automatic wcpu(input logic v);
      n = 0;
      while (cpu_en !== v) begin
         @(posedge clk);
         n++;
         if (n > 300) timeout();
      end
   endtask : wcpu

   task automatic sleep(input logic [7:0] v);
      w0 = wdt_n;
      axw(`IPC_POWER_CONTROL_ADDR, v);
      wcpu(1'b0);
      @(posedge clk);
      check(per_en, !v[1]);
      check({osc_en, fl_en}, {2{!v[1]}});
      v0 = pc;
      repeat (8) @(posedge clk);
      check(pc, v0);
      axr(`IPC_STATUS_ADDR);
      check(d[1:0], v[1] ? ipc_pkg::IPC_PDOWN : ipc_pkg::IPC_IDLE);
      check(wdt_n > w0, 1);
   endtask : sleep

   task automatic wake(input int k);
      w0 = wdt_n;
      r0 = rst_cnt;
      v0 = vec_n;
      ipc_cpu_model_i.fire(k);
      wcpu(1'b1);
      if (k < 5) check(n + 3 >= SETTLE, 1);
      repeat (2) @(posedge clk);
      check(wdt_n > w0, 1);
      if (k < 5 || k == 9) check(vec_n > v0, 1);
      else check(rst_cnt > r0, 1);
      axr(`IPC_POWER_CONTROL_ADDR);
      check(d[1:0], 2'h0);
      repeat (6) @(posedge clk);
      check(cpu_en, 1);
   endtask : wake

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 36;
      {fail_count, n_compared, wdt_n, rst_cnt, vec_n} = '0;
      {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
      rst_n = 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      ipc_cpu_model_i.fire(8);
      axr(`IPC_POWER_CONTROL_ADDR);
      check(d[4], 1);
      axw(`IPC_POWER_CONTROL_ADDR, 8'h00);
      axr(`IPC_POWER_CONTROL_ADDR);
      check(d[4], 0);
      // request bits kept clear: random flag traffic must not sleep
      for (i = 0; i < 6; i++) begin
         b = 8'($random(seed)) & 8'hFC;
         axw(`IPC_POWER_CONTROL_ADDR, b);
         check(r, `IPC_RESP_OKAY);
         axr(`IPC_POWER_CONTROL_ADDR);
         check(d[7:0], b & 8'hDC);
         check({baud, frm}, b[7:6]);
      end
      axr(8'h91);
      check(r, `IPC_RESP_SLVERR);
      $display("register test done");
      sleep(8'h01);
      wake(9);
      sleep(8'h01);
      wake(5);
      $display("idle test done");
      // reset sources last: they restart the cpu instead of vectoring
      for (i = 0; i < 9; i++) begin
         axw(`IPC_WAKE_ENABLE_ADDR, 8'h9F);
         sleep((i % 2) ? 8'h02 : 8'h03);
         wake(i);
      end
      $display("power-down wake test done");
      axw(`IPC_WAKE_ENABLE_ADDR, 8'h1F);
      sleep(8'h02);
      ipc_cpu_model_i.fire(0);
      repeat (30) @(posedge clk);
      check(cpu_en, 0);
      wake(5);
      $display("global enable test done");
      results();
   end
endmodule : tb
